// >>> lcdcfg_decoder.v
// command decoder and configuration state for the lcd segment driver
// Function
// - slope commands need group 10 and write
// - prefixes 1..6 store slope codes A..F
// - each slope code serves one temperature interval
// - ratio command in group 00 sets multiplex
// - inversion command picks frame or n-line
// - polarity inversion cancels net DC drive
// - n-line mode flips polarity every n lines
// - frame mode flips polarity every frame
// - display command bit 0 enables display
// - all logic runs from i_clk; the drive clock is sampled as an enable
// - drive clock paces data and frame timing
// - frame rate is drive clock over 144
`timescale 1ns/10ps
`include "lcdcfg_map.vh"
module lcdcfg_decoder #(
   parameter FRAME_DIV = `LCDCFG_FRAME_DIV
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_drive_clk,
   input wire i_cmd_valid,
   input wire i_cmd_rw,
   input wire [1:0] i_command_group_sel,
   input wire [7:0] i_cmd_byte,
   output wire [2:0] o_slope_a_code,
   output wire [2:0] o_slope_b_code,
   output wire [2:0] o_slope_c_code,
   output wire [2:0] o_slope_d_code,
   output wire [2:0] o_slope_e_code,
   output wire [2:0] o_slope_f_code,
   output reg [2:0] o_drive_ratio_code,
   output reg [3:0] o_mux_lines,
   output reg [2:0] o_polarity_flip_sel,
   output reg o_display_on_bit,
   output reg o_cmd_reserved,
   output reg o_cmd_ignored,
   output wire o_frame_pulse,
   output wire o_line_pulse,
   output wire [3:0] o_line_idx,
   output wire o_polarity
);
   // drive clock pin synchroniser and rising edge detect
   reg drv_meta_reg; // first stage, read only by second stage
   reg drv_sync_reg; // second stage
   reg drv_prev_reg; // delayed copy for edge detect
   reg drive_tick; // one-cycle enable per drive clock period
   // decoded command fields
   wire [4:0] prefix5;
   wire [6:0] prefix7;
   wire [2:0] arg3;
   wire is_write;
   wire hit_slope;
   wire hit_ratio;
   wire hit_inv;
   wire hit_disp;
   wire ratio_rsvd;
   reg [3:0] lines_next; // backplane count for selected ratio
   // slope storage
   localparam SLOPE_CNT = 6; // temperature intervals, one slope each
   wire [17:0] slope_bus; // six 3-bit slope codes, slope A in the low bits
   genvar gi; // slope slot index

   assign prefix5 = i_cmd_byte[7:3];
   assign prefix7 = i_cmd_byte[7:1];
   assign arg3 = i_cmd_byte[2:0];
   assign is_write = ~i_cmd_rw;

   // slope commands only in group 10 with the rw flag clear
   assign hit_slope = i_cmd_valid & is_write & (i_command_group_sel == `LCDCFG_GRP_TEMP)
      & (prefix5 >= `LCDCFG_PFX_SLOPE_A) & (prefix5 <= `LCDCFG_PFX_SLOPE_F);
   // display control commands live in group 00
   assign hit_ratio = i_cmd_valid & is_write & (i_command_group_sel == `LCDCFG_GRP_CTRL)
      & (prefix5 == `LCDCFG_PFX_RATIO);
   assign hit_inv = i_cmd_valid & is_write & (i_command_group_sel == `LCDCFG_GRP_CTRL)
      & (prefix5 == `LCDCFG_PFX_INV);
   assign hit_disp = i_cmd_valid & is_write & (i_command_group_sel == `LCDCFG_GRP_CTRL)
      & (prefix7 == `LCDCFG_PFX7_DISP);
   // undefined ratio codes are refused rather than stored
   assign ratio_rsvd = (arg3 == `LCDCFG_RATIO_RSVD1) | (arg3 == `LCDCFG_RATIO_RSVD2);

   // the drive clock is asynchronous, so it is sampled twice before use
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         drv_meta_reg <= 1'b0;
         drv_sync_reg <= 1'b0;
         drv_prev_reg <= 1'b0;
         drive_tick <= 1'b0;
      end else begin
         drv_meta_reg <= i_drive_clk;
         drv_sync_reg <= drv_meta_reg;
         drv_prev_reg <= drv_sync_reg;
         drive_tick <= drv_sync_reg & ~drv_prev_reg;
      end
   end

   // ratio code to number of backplanes driven per frame
   always @* begin
      case (o_drive_ratio_code)
         3'h0: lines_next = 4'h9;
         3'h3: lines_next = 4'h8;
         3'h4: lines_next = 4'h6;
         3'h5: lines_next = 4'h4;
         3'h6: lines_next = 4'h2;
         3'h7: lines_next = 4'h1;
         default: lines_next = 4'h9; // never stored; kept safe anyway
      endcase
   end

   // configuration store; each command touches only its own field, and the
   // hit terms are mutually exclusive, so no two processes ever race

   // slope codes leave the block as six ports cut from one flat bus, three bits per interval
   assign o_slope_a_code = slope_bus[2:0];
   assign o_slope_b_code = slope_bus[5:3];
   assign o_slope_c_code = slope_bus[8:6];
   assign o_slope_d_code = slope_bus[11:9];
   assign o_slope_e_code = slope_bus[14:12];
   assign o_slope_f_code = slope_bus[17:15];

   // one slope register per temperature interval; prefix k+1 owns slot k
   // the six slots are alike, so a single loop builds them all
   generate
      for (gi = 0; gi < SLOPE_CNT; gi = gi + 1) begin : g_slope
         wire slot_hit; // this slot is addressed by a taken slope write
         reg [2:0] code_reg; // stored slope code for this interval
         assign slot_hit = hit_slope & (prefix5 == gi + 1);
         assign slope_bus[3 * gi +: 3] = code_reg;
         // a slot only moves when its own prefix arrives
         always @(posedge i_clk) begin
            if (!i_rst_n) begin
               code_reg <= `LCDCFG_SLOPE_RST;
            end else if (slot_hit) begin
               code_reg <= arg3;
            end
         end
      end
   endgenerate

   // multiplex ratio; reserved codes are flagged and never stored
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_drive_ratio_code <= `LCDCFG_RATIO_RST;
      end else if (hit_ratio && !ratio_rsvd) begin
         o_drive_ratio_code <= arg3;
      end
   end

   // inversion scheme: 000 frame, 1..7 n-line with n equal to the code
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_polarity_flip_sel <= `LCDCFG_INV_RST;
      end else if (hit_inv) begin
         o_polarity_flip_sel <= arg3;
      end
   end

   // display enable; while it is low the frame timer is held cleared at line 0
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_display_on_bit <= `LCDCFG_DISP_RST;
      end else if (hit_disp) begin
         o_display_on_bit <= i_cmd_byte[0];
      end
   end

   // status pulses, each high only in the cycle after the byte is taken
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cmd_reserved <= 1'b0;
         o_cmd_ignored <= 1'b0;
      end else begin
         // a reserved ratio code is still a recognised command, not an ignored one
         o_cmd_reserved <= hit_ratio & ratio_rsvd;
         // no match: flag it, configuration stays as it was
         o_cmd_ignored <= i_cmd_valid & ~(hit_slope | hit_ratio | hit_inv | hit_disp);
      end
   end

   // registered line count so the timer sees a stable value
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_mux_lines <= 4'h9;
      end else begin
         o_mux_lines <= lines_next;
      end
   end

   // frame timing from the drive clock; trade-off: a ratio change mid frame
   // can shorten or lengthen that frame, it never stops the polarity alternation
   lcdcfg_frame_timer #(
      .FRAME_DIV(FRAME_DIV)
   ) u_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_drive_tick(drive_tick),
      .i_lines(o_mux_lines),
      .i_inv_sel(o_polarity_flip_sel),
      .i_enable(o_display_on_bit),
      .o_frame_pulse(o_frame_pulse),
      .o_line_pulse(o_line_pulse),
      .o_line_idx(o_line_idx),
      .o_polarity(o_polarity)
   );
endmodule

// >>> lcdcfg_frame_timer.v
// frame and line timing divider with polarity generation
`timescale 1ns/10ps
`include "lcdcfg_map.vh"
module lcdcfg_frame_timer #(
   parameter FRAME_DIV = `LCDCFG_FRAME_DIV
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_drive_tick,
   input wire [3:0] i_lines,
   input wire [2:0] i_inv_sel,
   input wire i_enable,
   output reg o_frame_pulse,
   output reg o_line_pulse,
   output reg [3:0] o_line_idx,
   output reg o_polarity
);
   // drive ticks per frame split evenly over the lines of the frame
   reg [7:0] tick_cnt_reg; // ticks within current line
   reg [7:0] line_len; // ticks per line
   reg [2:0] grp_cnt_reg; // lines since last n-line flip
   wire [31:0] div_full; // full-width quotient, cut to the line length below
   wire [31:0] last_end; // final tick index of the last line
   wire last_tick;
   wire last_line;

   // integer divide; remainder ticks are absorbed by the last line
   assign div_full = FRAME_DIV / i_lines;
   always @* begin
      line_len = div_full[7:0];
   end
   assign last_end = FRAME_DIV - 1 - line_len * (i_lines - 4'h1);

   // compares use >= so a ratio change mid frame cannot strand the counters
   assign last_line = (o_line_idx >= i_lines - 4'h1);
   assign last_tick = last_line ? (tick_cnt_reg >= last_end[7:0])
      : (tick_cnt_reg >= line_len - 8'h01);

   // line and frame sequencing, paced only by the drive clock tick
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         tick_cnt_reg <= 8'h00;
         o_line_idx <= 4'h0;
         o_frame_pulse <= 1'b0;
         o_line_pulse <= 1'b0;
         o_polarity <= 1'b0;
         grp_cnt_reg <= 3'h0;
      end else begin
         o_frame_pulse <= 1'b0;
         o_line_pulse <= 1'b0;
         if (!i_enable) begin
            // idle: clear counters, no pulses while display is off
            tick_cnt_reg <= 8'h00;
            o_line_idx <= 4'h0;
            grp_cnt_reg <= 3'h0;
         end else if (i_drive_tick) begin
            if (last_tick) begin
               tick_cnt_reg <= 8'h00;
               o_line_pulse <= 1'b1;
               if (last_line) begin
                  o_line_idx <= 4'h0;
                  o_frame_pulse <= 1'b1;
               end else begin
                  o_line_idx <= o_line_idx + 4'h1;
               end
               if (i_inv_sel == `LCDCFG_INV_RST) begin
                  // frame scheme: flip only at frame end, balance spans two frames
                  grp_cnt_reg <= 3'h0;
                  if (last_line) begin
                     o_polarity <= ~o_polarity;
                  end
               end else if (grp_cnt_reg >= i_inv_sel - 3'h1) begin
                  // n-line scheme: flip after every n lines
                  grp_cnt_reg <= 3'h0;
                  o_polarity <= ~o_polarity;
               end else begin
                  grp_cnt_reg <= grp_cnt_reg + 3'h1;
               end
            end else begin
               tick_cnt_reg <= tick_cnt_reg + 8'h01;
            end
         end
      end
   end
endmodule

// >>> lcdcfg_host_model.sv
// host model that issues configuration command bytes to the decoder
`timescale 1ns/10ps
module lcdcfg_host_model (
   input wire i_clk,
   output reg o_valid = 1'b0,
   output reg o_rw = 1'b0,
   output reg [1:0] o_grp = 2'h0,
   output reg [7:0] o_byte = 8'h00
);
   // one byte per call; after the taken edge the lines show junk, not the old byte
   task send(input [1:0] g, input r, input [7:0] b);
      begin
         @(posedge i_clk);
         o_valid <= 1'b1;
         o_rw <= r;
         o_grp <= g;
         o_byte <= b;
         @(posedge i_clk);
         o_valid <= 1'b0;
         o_rw <= ~r;
         o_grp <= ~g;
         o_byte <= ~b;
      end
   endtask
endmodule

// >>> lcdcfg_map.vh
// constants for the lcd drive configuration decoder
`ifndef LCDCFG_MAP_VH
`define LCDCFG_MAP_VH
`define LCDCFG_GRP_CTRL 2'h0
`define LCDCFG_GRP_TEMP 2'h2
`define LCDCFG_PFX_RATIO 5'h00
`define LCDCFG_PFX_INV 5'h16
`define LCDCFG_PFX7_DISP 7'h1C
`define LCDCFG_PFX_SLOPE_A 5'h01
`define LCDCFG_PFX_SLOPE_F 5'h06
`define LCDCFG_SLOPE_RST 3'h0
`define LCDCFG_RATIO_RST 3'h0
`define LCDCFG_INV_RST 3'h0
`define LCDCFG_DISP_RST 1'h0
`define LCDCFG_RATIO_RSVD1 3'h1
`define LCDCFG_RATIO_RSVD2 3'h2
`define LCDCFG_FRAME_DIV 144
`endif

// >>> lcdcfg_sva.sv
// assertions for the lcd drive configuration decoder
`timescale 1ns/10ps
module lcdcfg_sva (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_cmd_valid,
   input wire i_cmd_rw,
   input wire [1:0] i_command_group_sel,
   input wire [7:0] i_cmd_byte,
   input wire [2:0] o_slope_a_code,
   input wire [2:0] o_slope_f_code,
   input wire [2:0] o_drive_ratio_code,
   input wire [3:0] o_mux_lines,
   input wire [2:0] o_polarity_flip_sel,
   input wire o_display_on_bit,
   input wire o_cmd_reserved,
   input wire o_cmd_ignored,
   input wire o_frame_pulse,
   input wire o_line_pulse,
   input wire [3:0] o_line_idx,
   input wire o_polarity
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // taken writes in the control and temperature groups
   wire wr0 = i_cmd_valid && !i_cmd_rw && i_command_group_sel == 2'h0;
   wire wr2 = i_cmd_valid && !i_cmd_rw && i_command_group_sel == 2'h2;
   wire rsvd = i_cmd_byte[2:0] == 3'h1 || i_cmd_byte[2:0] == 3'h2;
   sequence ratio_wr;
      wr0 && i_cmd_byte[7:3] == 5'h00;
   endsequence
   AST_SLOPE_A: assert property (wr2 && i_cmd_byte[7:3] == 5'h01
      |=> o_slope_a_code == $past(i_cmd_byte[2:0])) else $error("slope a not stored");
   AST_SLOPE_F: assert property (wr2 && i_cmd_byte[7:3] == 5'h06
      |=> o_slope_f_code == $past(i_cmd_byte[2:0])) else $error("slope f not stored");
   AST_READ: assert property (i_cmd_valid && i_cmd_rw
      |=> o_cmd_ignored && $stable(o_slope_a_code)) else $error("read acted");
   AST_RATIO: assert property (ratio_wr ##0 !rsvd
      |=> o_drive_ratio_code == $past(i_cmd_byte[2:0])) else $error("ratio not stored");
   AST_RSVD: assert property (ratio_wr ##0 rsvd
      |=> o_cmd_reserved && $stable(o_drive_ratio_code)) else $error("reserved stored");
   AST_STATIC: assert property ($past(o_drive_ratio_code) == 3'h7
      |-> o_mux_lines == 4'h1) else $error("static line count wrong");
   AST_INV: assert property (wr0 && i_cmd_byte[7:3] == 5'h16
      |=> o_polarity_flip_sel == $past(i_cmd_byte[2:0])) else $error("inversion not stored");
   AST_DISP: assert property (wr0 && i_cmd_byte[7:1] == 7'h1C
      |=> o_display_on_bit == $past(i_cmd_byte[0])) else $error("display bit not stored");
   AST_FRAME_FLIP: assert property (o_frame_pulse && $past(o_polarity_flip_sel) == 3'h0
      |-> $changed(o_polarity)) else $error("frame flip missing");
   AST_NLINE: assert property (o_line_pulse && $past(o_polarity_flip_sel) == 3'h1
      |-> $changed(o_polarity)) else $error("line flip missing");
   AST_FRAME_LINE: assert property (o_frame_pulse
      |-> o_line_pulse && o_line_idx == 4'h0) else $error("frame not on last line");
   AST_OFF: assert property (!o_display_on_bit [*3]
      |-> !o_frame_pulse && !o_line_pulse) else $error("pulse while off");
endmodule
bind lcdcfg_decoder lcdcfg_sva u_sva (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_rw,
   .i_command_group_sel, .i_cmd_byte, .o_slope_a_code, .o_slope_f_code,
   .o_drive_ratio_code, .o_mux_lines, .o_polarity_flip_sel, .o_display_on_bit,
   .o_cmd_reserved, .o_cmd_ignored, .o_frame_pulse, .o_line_pulse, .o_line_idx, .o_polarity);

// >>> testbench.sv
// self-checking bench for the lcd drive configuration decoder
`timescale 1ns/10ps
module testbench;
   reg i_clk = 1'b0;
   reg i_rst_n = 1'b0;
   reg i_drive_clk = 1'b0;
   wire v, rw, rsv, ign, disp, fp, lp, pol;
   wire [1:0] grp;
   wire [7:0] cb;
   wire [2:0] sa, sb, sc, sd, se, sf, ratio, inv;
   wire [3:0] mux, lidx;
   integer fails = 0;
   integer checked = 0;
   integer s [0:5];
   integer e_ratio = 0, e_inv = 0, e_disp = 0, k, n, h, nl, nf;
   reg [31:0] seed = 32'h000117C1;
   reg p1, pp;
   time t1;
   lcdcfg_host_model host (.i_clk(i_clk), .o_valid(v), .o_rw(rw), .o_grp(grp), .o_byte(cb));
   lcdcfg_decoder dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_drive_clk(i_drive_clk),
      .i_cmd_valid(v), .i_cmd_rw(rw), .i_command_group_sel(grp), .i_cmd_byte(cb),
      .o_slope_a_code(sa), .o_slope_b_code(sb), .o_slope_c_code(sc), .o_slope_d_code(sd),
      .o_slope_e_code(se), .o_slope_f_code(sf), .o_drive_ratio_code(ratio),
      .o_mux_lines(mux), .o_polarity_flip_sel(inv), .o_display_on_bit(disp),
      .o_cmd_reserved(rsv), .o_cmd_ignored(ign), .o_frame_pulse(fp), .o_line_pulse(lp),
      .o_line_idx(lidx), .o_polarity(pol));
   initial forever #4 i_clk = ~i_clk;
   // drive clock period of ten system cycles, running free
   always begin
      repeat (5) @(posedge i_clk);
      i_drive_clk <= ~i_drive_clk;
   end
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   task chk(input [63:0] name, input [3:0] seen, input [3:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %0s expected %0d seen %0d", name, exp, seen);
         end
      end
   endtask
   // send one byte, update the model, compare every configuration output
   task cmd(input [1:0] g, input r, input [7:0] b);
      begin
         host.send(g, r, b);
         n = !r && g == 2'h0 && b[7:3] == 5'h00 && (b[2:0] == 3'h1 || b[2:0] == 3'h2);
         if (!r && g == 2'h2 && b[7:3] >= 1 && b[7:3] <= 6) s[b[7:3] - 1] = b[2:0];
         if (!r && g == 2'h0 && b[7:3] == 5'h00 && n == 0) e_ratio = b[2:0];
         if (!r && g == 2'h0 && b[7:3] == 5'h16) e_inv = b[2:0];
         if (!r && g == 2'h0 && b[7:1] == 7'h1C) e_disp = b[0];
         #1;
         chk("reserved", rsv, n);
         h = !r && ((g == 2'h2 && b[7:3] >= 1 && b[7:3] <= 6)
            || (g == 2'h0 && (b[7:3] == 5'h00 || b[7:3] == 5'h16 || b[7:1] == 7'h1C)));
         chk("ignored", ign, !h);
         @(posedge i_clk);
         #1;
         chk("slope_a", sa, s[0]);
         chk("slope_b", sb, s[1]);
         chk("slope_c", sc, s[2]);
         chk("slope_d", sd, s[3]);
         chk("slope_e", se, s[4]);
         chk("slope_f", sf, s[5]);
         chk("ratio", ratio, e_ratio);
         chk("lines", mux, e_ratio == 0 ? 9 : e_ratio == 7 ? 1 : 14 - 2 * e_ratio);
         chk("inv", inv, e_inv);
         chk("display", disp, e_disp);
      end
   endtask
   // wait for a frame pulse, counting line pulses and polarity flips on the way
   task wfp;
      begin
         n = 0;
         nl = 0;
         nf = 0;
         pp = pol;
         @(posedge i_clk);
         #1;
         while (fp !== 1'b1 && n < 3000) begin
            if (lp === 1'b1) nl = nl + 1;
            if (pol !== pp) nf = nf + 1;
            pp = pol;
            @(posedge i_clk);
            #1;
            n = n + 1;
         end
         if (lp === 1'b1) nl = nl + 1;
         if (pol !== pp) nf = nf + 1;
         chk("frame_in", fp, 1);
      end
   endtask
   task results;
      begin
         $display("checked %0d fails %0d", checked, fails);
         if (fails == 0 && checked > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   initial begin
      #500000;
      fails = fails + 1;
      results;
   end
   initial begin
      for (k = 0; k < 6; k = k + 1) s[k] = 0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (k = 0; k < 8; k = k + 1) cmd(2'h0, 1'b0, k[7:0]);
      for (k = 7; k >= 0; k = k - 1) cmd(2'h0, 1'b0, {5'h16, k[2:0]});
      for (k = 1; k < 7; k = k + 1) cmd(2'h2, 1'b0, {k[4:0], ~k[2:0]});
      cmd(2'h2, 1'b1, 8'h0F);
      cmd(2'h0, 1'b0, 8'h39);
      // static drive in frame mode: one frame every 144 drive ticks
      wfp;
      t1 = $time;
      repeat (3) @(posedge i_clk);
      p1 = pol;
      wfp;
      chk("frame", ($time - t1) == 11520, 1);
      chk("frm_line", nl, 1);
      chk("flips", nf, 1);
      repeat (3) @(posedge i_clk);
      chk("polarity", pol, !p1);
      // 1:9 drive with 3-line inversion: nine lines and three flips per frame
      cmd(2'h0, 1'b0, 8'h00);
      cmd(2'h0, 1'b0, 8'hB3);
      wfp;
      wfp;
      chk("frm_line", nl, 9);
      chk("flips", nf, 3);
      chk("line_idx", lidx, 0);
      // 1-line inversion: a flip after every line
      cmd(2'h0, 1'b0, 8'hB1);
      wfp;
      wfp;
      chk("flips", nf, 9);
      cmd(2'h0, 1'b0, 8'h38);
      for (k = 0; k < 300; k = k + 1) begin
         seed = xs(seed);
         cmd(seed[9:8], seed[10] & seed[11], seed[7:0]);
      end
      results;
   end
endmodule
